// *** osd_pkg.sv ***
// Constants and types for the oversampled serial transceiver
// Assumes a single clock domain with an active-low asynchronous reset
//
// Behaviour
// - Frame: start, eight data, stop bits
// - Sampling tick runs at four times bitrate
// - Tick divides clock by 480 times reload
// - Tick base free-runs, shared, never altered
// - Idle SPACE on tick starts receive, clears finished
// - Recheck start: sync, load 80H, count four
// - Synced: decrement counter, act at one, reload
// - Shift input right until marker falls out
// - On completion copy byte, set finished
// - Data-ready still set: overwrite, set overrun
// - Stop MARK sets ready, SPACE framing error
// - Transmitter runs after receiver each tick
// - Transmit acts when tick count mod 4 zero
// - Pending request loads byte, sends start bit
// - Stop MARK at 0x24, done at 0x24, or at 0x28 with two stop bits
package osd_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned OSD_CLK_DIV_BASE  = 480;
    localparam int unsigned OSD_RELOAD_DFLT   = 2;
    localparam int unsigned OSD_TICKS_PER_BIT = 4;

    // ----------------------------------------------------------------
    // Receiver constants
    // ----------------------------------------------------------------
    localparam logic [7:0] OSD_RX_MARKER   = 8'h80;
    localparam logic [2:0] OSD_SAMPLE_LOAD = 3'h4;
    localparam logic [2:0] OSD_SAMPLE_ZERO = 3'h0;

    // ----------------------------------------------------------------
    // Transmitter constants
    // ----------------------------------------------------------------
    localparam logic [7:0] OSD_TX_STOP_CNT = 8'h24;
    localparam logic [7:0] OSD_TX_END_CNT  = 8'h28;
    localparam logic [7:0] OSD_TX_CNT_ZERO = 8'h00;
    localparam logic [1:0] OSD_TX_PHASE0   = 2'h0;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [2:0] OSD_ADDR_STATUS = 3'h0;
    localparam logic [2:0] OSD_ADDR_RXDATA = 3'h1;
    localparam logic [2:0] OSD_ADDR_TXDATA = 3'h2;
    localparam logic [2:0] OSD_ADDR_CTRL   = 3'h3;

    localparam int unsigned OSD_ST_DRDY  = 0;
    localparam int unsigned OSD_ST_FERR  = 1;
    localparam int unsigned OSD_ST_OVRN  = 2;
    localparam int unsigned OSD_ST_TXREQ = 3;
    localparam int unsigned OSD_ST_TXING = 4;
    localparam int unsigned OSD_CTRL_TWO_STOP = 0;

    localparam logic       OSD_MARK  = 1'b1;
    localparam logic       OSD_SPACE = 1'b0;

    typedef enum logic [1:0] {
        OSD_RX_IDLE,
        OSD_RX_START,
        OSD_RX_SYNC
    } osd_rx_state_t;

    function automatic logic [7:0] osd_sel_byte(input logic [7:0] a, input logic [7:0] b,
                                                input logic s);
        return s ? b : a;
    endfunction

endpackage

// *** osd_tick_if.sv ***
// Interface carrying the shared sampling tick
// Assumes one clock; tick is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
interface osd_tick_if;
    logic tick;
    modport src (output tick);
    modport dst (input tick);
endinterface
`default_nettype wire

// *** osd_tick_gen.sv ***
// Free-running sampling tick generator
// Assumes clk is the device input clock
`timescale 1ns/1ps
`default_nettype none
module osd_tick_gen
    import osd_pkg::*;
#(
    parameter int unsigned RELOAD = OSD_RELOAD_DFLT
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // Tick out
    osd_tick_if.src   tk
);
    localparam int unsigned DIV = OSD_CLK_DIV_BASE * RELOAD;
    localparam int unsigned CW  = $clog2(DIV);

    if (RELOAD < 1) begin : g_bad_reload
        $error("RELOAD must be at least one");
    end

    logic [CW-1:0] div_ff;
    logic          tick_ff;
    wire           wrap = (div_ff == CW'(DIV - 1));
    wire  [CW-1:0] nxt_div = wrap ? '0 : div_ff + 1'b1;

    // Constant reload, never touched by the serial logic
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            div_ff  <= '0;
            tick_ff <= 1'b0;
        end else begin
            div_ff  <= nxt_div;
            tick_ff <= wrap;
        end
    end

    assign tk.tick = tick_ff;

    property p_tick_period;
        @(posedge clk) disable iff (!resetn)
        $rose(tick_ff) |=> !tick_ff;
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("tick wider than one cycle");
endmodule
`default_nettype wire

// *** osd_uart.sv ***
// Full-duplex oversampled asynchronous serial transceiver, top level
// Assumes a synchronous serial input and a simple strobe register port
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module osd_uart
    import osd_pkg::*;
#(
    parameter int unsigned RELOAD = OSD_RELOAD_DFLT
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // Register port
    input  wire logic [2:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    // Serial line
    input  wire logic       serial_input_pin,
    output logic            serial_output_pin
);
    // ----------------------------------------------------------------
    // Tick
    // ----------------------------------------------------------------
    osd_tick_if tk ();
    osd_tick_gen #(.RELOAD(RELOAD)) u_tick (
        .clk    (clk),
        .resetn (resetn),
        .tk     (tk.src)
    );
    wire tick = tk.tick;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    osd_rx_state_t rx_st_ff, nxt_rx_st;
    logic [7:0] rx_shift_ff, nxt_rx_shift;
    logic [7:0] rx_hold_ff, nxt_rx_hold;
    logic [2:0] samp_ff, nxt_samp;
    logic       fin_ff, nxt_fin;
    logic       drdy_ff, nxt_drdy;
    logic       ferr_ff, nxt_ferr;
    logic       ovrn_ff, nxt_ovrn;
    logic [7:0] next_transmit_byte;
    logic [7:0] transmit_shift_byte, nxt_tx_shift;
    logic       txreq_ff, nxt_txreq;
    logic       txing_ff, nxt_txing;
    logic [7:0] tcnt_ff, nxt_tcnt;
    logic       out_ff, nxt_out;
    logic       two_stop_ff;
    logic [7:0] rdata_ff, nxt_rdata;

    // ----------------------------------------------------------------
    // Register decode
    // ----------------------------------------------------------------
    wire wr_st   = wr && (addr == OSD_ADDR_STATUS);
    wire wr_tx   = wr && (addr == OSD_ADDR_TXDATA);
    wire wr_ctrl = wr && (addr == OSD_ADDR_CTRL);
    wire clr_drdy  = wr_st && wdata[OSD_ST_DRDY];
    wire clr_ferr  = wr_st && wdata[OSD_ST_FERR];
    wire clr_ovrn  = wr_st && wdata[OSD_ST_OVRN];
    wire set_txreq = wr_st && wdata[OSD_ST_TXREQ];

    wire [7:0] status = {3'h0, txing_ff, txreq_ff, ovrn_ff, ferr_ff, drdy_ff};

    assign nxt_rdata = !rd ? 8'h00 :
                       (addr == OSD_ADDR_STATUS) ? status :
                       (addr == OSD_ADDR_RXDATA) ? rx_hold_ff :
                       (addr == OSD_ADDR_TXDATA) ? next_transmit_byte :
                       (addr == OSD_ADDR_CTRL)   ? {7'h00, two_stop_ff} : 8'h00;

    // ----------------------------------------------------------------
    // Receiver
    // ----------------------------------------------------------------
    wire       rx_in     = serial_input_pin;
    wire       samp_hit  = (samp_ff == 3'(OSD_SAMPLE_ZERO + 3'h1));
    wire [7:0] shifted   = {rx_in, rx_shift_ff[7:1]};
    wire       byte_done = rx_shift_ff[0];
    logic      ev_drdy, ev_ferr, ev_ovrn;

    always_comb begin
        nxt_rx_st    = rx_st_ff;
        nxt_rx_shift = rx_shift_ff;
        nxt_rx_hold  = rx_hold_ff;
        nxt_samp     = samp_ff;
        nxt_fin      = fin_ff;
        ev_drdy      = 1'b0;
        ev_ferr      = 1'b0;
        ev_ovrn      = 1'b0;
        if (tick) begin
            case (rx_st_ff)
                OSD_RX_IDLE: begin
                    if (rx_in == OSD_SPACE) begin
                        nxt_rx_st = OSD_RX_START;
                        nxt_fin   = 1'b0;
                    end
                end
                OSD_RX_START: begin
                    if (rx_in == OSD_SPACE) begin
                        nxt_rx_st    = OSD_RX_SYNC;
                        nxt_rx_shift = OSD_RX_MARKER;
                        nxt_samp     = OSD_SAMPLE_LOAD;
                    end else begin
                        nxt_rx_st = OSD_RX_IDLE;
                    end
                end
                OSD_RX_SYNC: begin
                    nxt_samp = samp_ff - 3'h1;
                    if (samp_hit) begin
                        nxt_samp = OSD_SAMPLE_LOAD;
                        if (!fin_ff) begin
                            nxt_rx_shift = shifted;
                            if (byte_done) begin
                                nxt_rx_hold = shifted;
                                nxt_fin     = 1'b1;
                                ev_ovrn     = drdy_ff;
                            end
                        end else begin
                            ev_drdy   = (rx_in == OSD_MARK);
                            ev_ferr   = (rx_in == OSD_SPACE);
                            nxt_rx_st = OSD_RX_IDLE;
                        end
                    end
                end
                default: nxt_rx_st = OSD_RX_IDLE;
            endcase
        end
    end

    // Hardware set wins over software clear
    assign nxt_drdy = ev_drdy | (drdy_ff & ~clr_drdy);
    assign nxt_ferr = ev_ferr | (ferr_ff & ~clr_ferr);
    assign nxt_ovrn = ev_ovrn | (ovrn_ff & ~clr_ovrn);

    // ----------------------------------------------------------------
    // Transmitter
    // ----------------------------------------------------------------
    wire [7:0] tcnt_inc = tcnt_ff + 8'h01;
    wire       tx_phase = (tcnt_inc[1:0] == OSD_TX_PHASE0);
    wire [7:0] end_cnt  = two_stop_ff ? OSD_TX_END_CNT : OSD_TX_STOP_CNT;
    logic      tx_take;

    always_comb begin
        nxt_tcnt     = tcnt_ff;
        nxt_tx_shift = transmit_shift_byte;
        nxt_txing    = txing_ff;
        nxt_out      = out_ff;
        tx_take      = 1'b0;
        // Evaluated after the receiver within the same tick
        if (tick) begin
            nxt_tcnt = tcnt_inc;
            if (tx_phase) begin
                if (txing_ff) begin
                    if (tcnt_inc == end_cnt) begin
                        nxt_txing = 1'b0;
                        nxt_out   = OSD_MARK;
                    end else if (tcnt_inc == OSD_TX_STOP_CNT) begin
                        nxt_out = OSD_MARK;
                    end else begin
                        nxt_out      = transmit_shift_byte[0];
                        nxt_tx_shift = {1'b0, transmit_shift_byte[7:1]};
                    end
                end else if (txreq_ff) begin
                    nxt_tx_shift = next_transmit_byte;
                    tx_take      = 1'b1;
                    nxt_txing    = 1'b1;
                    nxt_tcnt     = OSD_TX_CNT_ZERO;
                    nxt_out      = OSD_SPACE;
                end
            end
        end
    end

    assign nxt_txreq = set_txreq | (txreq_ff & ~tx_take);

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rx_st_ff    <= OSD_RX_IDLE;
            rx_shift_ff <= 8'h00;
            rx_hold_ff  <= 8'h00;
            samp_ff     <= 3'h0;
            fin_ff      <= 1'b0;
            drdy_ff     <= 1'b0;
            ferr_ff     <= 1'b0;
            ovrn_ff     <= 1'b0;
        end else begin
            rx_st_ff    <= nxt_rx_st;
            rx_shift_ff <= nxt_rx_shift;
            rx_hold_ff  <= nxt_rx_hold;
            samp_ff     <= nxt_samp;
            fin_ff      <= nxt_fin;
            drdy_ff     <= nxt_drdy;
            ferr_ff     <= nxt_ferr;
            ovrn_ff     <= nxt_ovrn;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            transmit_shift_byte <= 8'h00;
            next_transmit_byte  <= 8'h00;
            txreq_ff            <= 1'b0;
            txing_ff            <= 1'b0;
            tcnt_ff             <= 8'h00;
            out_ff              <= OSD_MARK;
            two_stop_ff         <= 1'b0;
            rdata_ff            <= 8'h00;
        end else begin
            transmit_shift_byte <= nxt_tx_shift;
            next_transmit_byte  <= osd_sel_byte(next_transmit_byte, wdata, wr_tx);
            txreq_ff            <= nxt_txreq;
            txing_ff            <= nxt_txing;
            tcnt_ff             <= nxt_tcnt;
            out_ff              <= nxt_out;
            two_stop_ff         <= wr_ctrl ? wdata[OSD_CTRL_TWO_STOP] : two_stop_ff;
            rdata_ff            <= nxt_rdata;
        end
    end

    assign rdata             = rdata_ff;
    assign serial_output_pin = out_ff;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_start;
        @(posedge clk) disable iff (!resetn)
        (tick && rx_st_ff == OSD_RX_IDLE && !rx_in) |=> (rx_st_ff == OSD_RX_START && !fin_ff);
    endproperty
    a_start: assert property (p_start) else $error("start not entered");

    property p_sync;
        @(posedge clk) disable iff (!resetn)
        (tick && rx_st_ff == OSD_RX_START && !rx_in) |=>
            (rx_st_ff == OSD_RX_SYNC && rx_shift_ff == OSD_RX_MARKER && samp_ff == OSD_SAMPLE_LOAD);
    endproperty
    a_sync: assert property (p_sync) else $error("sync load wrong");

    property p_noise;
        @(posedge clk) disable iff (!resetn)
        (tick && rx_st_ff == OSD_RX_START && rx_in) |=> rx_st_ff == OSD_RX_IDLE;
    endproperty
    a_noise: assert property (p_noise) else $error("noise not rejected");

    property p_samp;
        @(posedge clk) disable iff (!resetn)
        (tick && rx_st_ff == OSD_RX_SYNC && samp_ff > 3'h1) |=> samp_ff == $past(samp_ff) - 3'h1;
    endproperty
    a_samp: assert property (p_samp) else $error("sample count wrong");

    property p_done;
        @(posedge clk) disable iff (!resetn)
        (tick && rx_st_ff == OSD_RX_SYNC && samp_hit && !fin_ff && byte_done) |=>
            (fin_ff && rx_hold_ff == $past(shifted) && (ovrn_ff || !$past(drdy_ff)));
    endproperty
    a_done: assert property (p_done) else $error("byte completion wrong");

    property p_stop;
        @(posedge clk) disable iff (!resetn)
        (tick && rx_st_ff == OSD_RX_SYNC && samp_hit && fin_ff) |=>
            (rx_st_ff == OSD_RX_IDLE && (drdy_ff || ferr_ff));
    endproperty
    a_stop: assert property (p_stop) else $error("stop check wrong");

    property p_txstart;
        @(posedge clk) disable iff (!resetn)
        (tick && tx_phase && !txing_ff && txreq_ff) |=>
            (txing_ff && !serial_output_pin && tcnt_ff == OSD_TX_CNT_ZERO);
    endproperty
    a_txstart: assert property (p_txstart) else $error("start bit not sent");

    property p_txstop;
        @(posedge clk) disable iff (!resetn)
        (tick && txing_ff && tcnt_inc == OSD_TX_STOP_CNT) |=> serial_output_pin;
    endproperty
    a_txstop: assert property (p_txstop) else $error("stop bit not mark");

    property p_txhold;
        @(posedge clk) disable iff (!resetn)
        (tick && !tx_phase) |=> $stable(serial_output_pin);
    endproperty
    a_txhold: assert property (p_txhold) else $error("output moved off phase");

    property p_ovrn;
        @(posedge clk) disable iff (!resetn)
        (tick && rx_st_ff == OSD_RX_SYNC && samp_hit && !fin_ff && byte_done && drdy_ff) |=>
            ovrn_ff;
    endproperty
    a_ovrn: assert property (p_ovrn) else $error("overrun not flagged");

    property p_ferr;
        @(posedge clk) disable iff (!resetn)
        (tick && rx_st_ff == OSD_RX_SYNC && samp_hit && fin_ff && rx_in == OSD_SPACE) |=>
            ferr_ff;
    endproperty
    a_ferr: assert property (p_ferr) else $error("framing error not flagged");

    property p_txbit;
        @(posedge clk) disable iff (!resetn)
        (tick && tx_phase && txing_ff && tcnt_inc != end_cnt && tcnt_inc != OSD_TX_STOP_CNT) |=>
            serial_output_pin == $past(transmit_shift_byte[0]);
    endproperty
    a_txbit: assert property (p_txbit) else $error("data bit order wrong");

    property p_txend;
        @(posedge clk) disable iff (!resetn)
        (tick && tx_phase && txing_ff && tcnt_inc == end_cnt) |=>
            (!txing_ff && serial_output_pin);
    endproperty
    a_txend: assert property (p_txend) else $error("frame end wrong");
endmodule
`default_nettype wire

// *** osd_remote_term.sv ***
// Remote serial terminal model for the transceiver bench
// Assumes it shares clk with the device and the line idles at MARK
`timescale 1ns/1ps
`default_nettype none
module osd_remote_term #(
    parameter int unsigned BIT_CLKS = 1920
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // Line
    input  wire logic        line_in,
    output logic             line_out,
    // Send control: mode 0 good, 1 bad stop, 2 short glitch
    input  wire logic        send_go,
    input  wire logic [1:0]  send_mode,
    input  wire logic [7:0]  send_byte,
    output logic             send_busy,
    // Captured frames
    output logic             cap_valid,
    output logic [7:0]       cap_byte,
    output logic             cap_stop,
    output logic [31:0]      cap_gap
);
    logic [31:0] cyc        = 32'h0000_0000;
    logic [31:0] last_start = 32'h0000_0000;
    logic [9:0]  frame;

    always @(posedge clk) cyc <= cyc + 32'h0000_0001;

    // ----------------------------------------------------------------
    // Sender
    // ----------------------------------------------------------------
    initial begin
        line_out  = 1'b1;
        send_busy = 1'b0;
        forever begin
            @(posedge clk);
            if (send_go) begin
                send_busy <= 1'b1;
                if (send_mode == 2'h2) begin
                    line_out <= 1'b0;
                    repeat (BIT_CLKS / 4) @(posedge clk);
                end else begin
                    frame = {send_mode != 2'h1, send_byte, 1'b0};
                    for (int i = 0; i < 10; i++) begin
                        line_out <= frame[i];
                        repeat (BIT_CLKS) @(posedge clk);
                    end
                end
                line_out  <= 1'b1;
                send_busy <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Receiver, samples mid bit
    // ----------------------------------------------------------------
    initial begin
        cap_valid = 1'b0;
        cap_byte  = 8'h00;
        cap_stop  = 1'b0;
        cap_gap   = 32'h0000_0000;
        forever begin
            @(posedge clk);
            cap_valid <= 1'b0;
            if (resetn && line_in == 1'b0) begin
                cap_gap <= cyc - last_start;
                last_start = cyc;
                repeat (BIT_CLKS / 2) @(posedge clk);
                for (int i = 0; i < 8; i++) begin
                    repeat (BIT_CLKS) @(posedge clk);
                    cap_byte[i] <= line_in;
                end
                repeat (BIT_CLKS) @(posedge clk);
                cap_stop  <= line_in;
                cap_valid <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// *** osd_uart_tb_top.sv ***
// Self-checking bench for the serial transceiver top
// Assumes the remote terminal model and RELOAD of one for short bit times
`timescale 1ns/1ps
`default_nettype none
module osd_uart_tb_top
    import osd_pkg::*;
;
    localparam int unsigned RELOAD   = 1;
    localparam int unsigned BIT_CLKS = OSD_CLK_DIV_BASE * RELOAD * OSD_TICKS_PER_BIT;
    localparam int          LIMIT    = 30000;

    logic        clk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0, send_go = 1'b0;
    logic [2:0]  addr = 3'h0;
    logic [1:0]  send_mode = 2'h0;
    logic [7:0]  wdata = 8'h00, send_byte = 8'h00;
    logic [7:0]  rdata, cap_byte, d, fmask, tmask;
    logic        sin, sout, send_busy, cap_valid, cap_stop;
    logic [31:0] cap_gap, lfsr;
    logic [7:0]  tx_q[$], got_q[$];
    logic        stop_q[$];
    logic [31:0] gap_q[$];
    int          errors = 0, comparisons = 0;

    always #20 clk = ~clk;

    osd_uart #(.RELOAD(RELOAD)) DUT (
        .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .serial_input_pin(sin), .serial_output_pin(sout));

    osd_remote_term #(.BIT_CLKS(BIT_CLKS)) u_term (
        .clk(clk), .resetn(resetn), .line_in(sout), .line_out(sin), .send_go(send_go),
        .send_mode(send_mode), .send_byte(send_byte), .send_busy(send_busy),
        .cap_valid(cap_valid), .cap_byte(cap_byte), .cap_stop(cap_stop), .cap_gap(cap_gap));

    always @(posedge clk) begin
        if (cap_valid === 1'b1) begin
            got_q.push_back(cap_byte);
            stop_q.push_back(cap_stop);
            gap_q.push_back(cap_gap);
        end
    end

    // ----------------------------------------------------------------
    // Expectations
    // ----------------------------------------------------------------
    function automatic logic [31:0] lfsr_step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [7:0] exp_flags(input logic rdy, input logic fe, input logic ov);
        logic [7:0] v;
        v = 8'h00;
        v[OSD_ST_DRDY] = rdy;
        v[OSD_ST_FERR] = fe;
        v[OSD_ST_OVRN] = ov;
        return v;
    endfunction

    // Start to start spacing of two queued frames
    function automatic logic [31:0] exp_gap(input logic two);
        logic [31:0] t;
        t = {24'h00_0000, two ? OSD_TX_END_CNT : OSD_TX_STOP_CNT};
        return (t + OSD_TICKS_PER_BIT) * OSD_CLK_DIV_BASE * RELOAD;
    endfunction

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("ERROR at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("Counts: %0d comparisons, %0d errors", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic timeout();
        errors++;
        $display("ERROR at %0t: wait limit reached, got %h, expected %h", $time, 0, 1);
        wrap_up();
    endtask

    task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    task automatic rd_reg(input logic [2:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic chk_rd(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
        rd_reg(a, d);
        chk({24'h00_0000, d & m}, {24'h00_0000, e});
    endtask

    task automatic wait_tx_free();
        for (int k = 0; k < LIMIT; k++) begin
            rd_reg(OSD_ADDR_STATUS, d);
            if (d[OSD_ST_TXREQ] === 1'b0) return;
        end
        timeout();
    endtask

    task automatic send_frame(input logic [1:0] m, input logic [7:0] b);
        @(posedge clk);
        send_go   <= 1'b1;
        send_mode <= m;
        send_byte <= b;
        @(posedge clk);
        send_go   <= 1'b0;
        for (int k = 0; k < LIMIT; k++) begin
            @(posedge clk);
            #1;
            if (send_busy === 1'b0) begin
                repeat (BIT_CLKS / 2) @(posedge clk);
                return;
            end
        end
        timeout();
    endtask

    task automatic wait_caps(input int n);
        for (int k = 0; k < 2 * LIMIT; k++) begin
            @(posedge clk);
            if (got_q.size() >= n) return;
        end
        timeout();
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        lfsr = 32'h0001_861E;
        fmask = exp_flags(1'b1, 1'b1, 1'b1);
        tmask = (8'h01 << OSD_ST_TXREQ) | (8'h01 << OSD_ST_TXING);
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        #1;
        chk({31'h0000_0000, sout}, {31'h0000_0000, OSD_MARK});
        chk_rd(OSD_ADDR_STATUS, 8'hFF, 8'h00);
        @(posedge clk);
        #1;
        chk({24'h00_0000, rdata}, 32'h0000_0000);
        wr_reg(3'h6, 8'hFF);
        chk_rd(3'h6, 8'hFF, 8'h00);
        $display("Test reset and unmapped access done");
        for (int p = 0; p < 2; p++) begin
            wr_reg(OSD_ADDR_CTRL, {7'h00, p[0]});
            chk_rd(OSD_ADDR_CTRL, 8'hFF, {7'h00, p[0]});
            for (int j = 0; j < 2; j++) begin
                lfsr = lfsr_step(lfsr);
                tx_q.push_back(lfsr[7:0]);
                wait_tx_free();
                wr_reg(OSD_ADDR_TXDATA, lfsr[7:0]);
                chk_rd(OSD_ADDR_TXDATA, 8'hFF, lfsr[7:0]);
                wr_reg(OSD_ADDR_STATUS, 8'h01 << OSD_ST_TXREQ);
            end
            chk_rd(OSD_ADDR_STATUS, tmask, tmask);
            lfsr = lfsr_step(lfsr);
            if (p == 0) begin
                send_frame(2'h0, lfsr[7:0]);
                chk_rd(OSD_ADDR_STATUS, fmask, exp_flags(1'b1, 1'b0, 1'b0));
                chk_rd(OSD_ADDR_RXDATA, 8'hFF, lfsr[7:0]);
                lfsr = lfsr_step(lfsr);
                send_frame(2'h0, lfsr[7:0]);
                chk_rd(OSD_ADDR_STATUS, fmask, exp_flags(1'b1, 1'b0, 1'b1));
                chk_rd(OSD_ADDR_RXDATA, 8'hFF, lfsr[7:0]);
            end else begin
                send_frame(2'h2, 8'h00);
                chk_rd(OSD_ADDR_STATUS, fmask, 8'h00);
                send_frame(2'h1, lfsr[7:0]);
                chk_rd(OSD_ADDR_STATUS, fmask, exp_flags(1'b0, 1'b1, 1'b0));
                chk_rd(OSD_ADDR_RXDATA, 8'hFF, lfsr[7:0]);
            end
            wr_reg(OSD_ADDR_STATUS, fmask);
            chk_rd(OSD_ADDR_STATUS, fmask, 8'h00);
            wait_caps(2 * p + 2);
            for (int j = 2 * p; j < 2 * p + 2; j++) begin
                chk({24'h00_0000, got_q[j]}, {24'h00_0000, tx_q[j]});
                chk({31'h0000_0000, stop_q[j]}, {31'h0000_0000, OSD_MARK});
            end
            chk(gap_q[2 * p + 1], exp_gap(p[0]));
            $display("Test pass %0d done", p);
        end
        wrap_up();
    end
endmodule
`default_nettype wire
